/* File: core_io_regs.vh */
`ifndef CORE_IO_REGS_VH
`define CORE_IO_REGS_VH
`define ADDR_ALU_STATUS_FLAGS 8'h00
`define ADDR_STACK_POINTER 8'h02
`define ADDR_CLOCK_MODE_CONTROL 8'h03
`define ADDR_INTERRUPT_ENABLE_MASK 8'h04
`define ADDR_INTERRUPT_REQUEST 8'h05
`define ADDR_MULTIPLIER_OPERAND 8'h08
`define ADDR_MULTIPLIER_HIGH_RESULT 8'h09
`define FLAG_ZERO_POS 0
`define FLAG_CARRY_POS 1
`define FLAG_HALF_CARRY_POS 2
`define FLAG_SIGNED_WRAP_POS 3
`define CLK_PIN_FUNC_POS 0
`define CLK_WATCHDOG_POS 1
`define CLK_SLOW_OSC_POS 2
`define CLK_TYPE_POS 3
`define CLK_FAST_OSC_POS 4
`define CLK_SEL_LSB 5
`define RST_FLAGS 4'h0
`define RST_STACK_POINTER 8'h00
`define RST_CLOCK_MODE 8'hf6
`define RST_INT_ENABLE 8'h00
`define RST_INT_REQUEST 8'h00
`define RST_OPERAND 8'h00
`define RST_HIGH_RESULT 8'h00
`define SRC_FAST 2'h0
`define SRC_SLOW 2'h1
`define SRC_CRYSTAL 2'h2
`define SRC_NONE 2'h3
`endif

/* File: core_status_clock_irq_regs.v */
// Contract
// - One-cycle 8x8 unsigned multiply
// - High byte to result, low to work
// - Bit 3 set on signed overflow
// - Bit 2 is nibble half carry/borrow
// - Bit 1 carry/borrow, also shift-through-carry
// - Bit 0 set when result is zero
// - Stack pointer readable and writable
// - Type 0 and type 1 clock source tables
// - Clock bit 3 picks table, reset 0
// - Clock bit 4 fast oscillator enable
// - Clock bit 2 slow oscillator, stops watchdog
// - Clock bit 1 watchdog enable
// - Clock bit 0 selects reset pin function
// - Enable bits gate each source, reset 0
// - Build option picks sources for bits 7,4
// - Sources set request bits, software clears
`timescale 1ns/10ps
`include "core_io_regs.vh"
module core_status_clock_irq_regs #(
   parameter BIT7_USES_GENERATOR_TWO = 0,
   parameter BIT4_USES_GENERATOR_ONE = 0
)(
   input wire i_mclk,
   input wire i_reset,
   input wire [7:0] i_io_addr,
   input wire i_io_wr,
   input wire [7:0] i_io_wdata,
   input wire i_io_rd,
   output reg [7:0] o_io_rdata,
   input wire i_mul_go,
   input wire [7:0] i_work_register,
   output reg [7:0] o_work_register_low,
   output reg o_work_register_load,
   input wire i_flag_zero_we,
   input wire i_flag_zero,
   input wire i_flag_carry_we,
   input wire i_flag_carry,
   input wire i_flag_half_carry_we,
   input wire i_flag_half_carry,
   input wire i_flag_signed_wrap_we,
   input wire i_flag_signed_wrap,
   input wire i_third_timer_evt,
   input wire i_pulse_generator_two_evt,
   input wire i_second_timer_evt,
   input wire i_pulse_generator_zero_evt,
   input wire i_comparator_evt,
   input wire i_pulse_generator_one_evt,
   input wire i_adc_evt,
   input wire i_sixteen_bit_timer_evt,
   input wire i_pin_pair_b_evt,
   input wire i_pin_pair_a_evt,
   output wire o_irq,
   output wire [7:0] o_irq_pending,
   output wire [7:0] o_stack_pointer,
   output wire [3:0] o_alu_status_flags,
   output reg [1:0] o_clk_source,
   output reg [6:0] o_clk_divide_log2,
   output reg o_clk_sel_reserved,
   output wire o_fast_internal_oscillator_en,
   output wire o_slow_internal_oscillator_en,
   output wire o_watchdog_run,
   output wire o_external_reset_pin_en
);
   reg [3:0] flags_r;
   reg [7:0] stack_pointer_r;
   reg [7:0] clock_mode_r;
   reg [7:0] int_enable_r;
   reg [7:0] int_request_r;
   reg [7:0] operand_r;
   reg [7:0] high_result_r;
   reg [3:0] flags_nxt;
   reg [7:0] stack_pointer_nxt;
   reg [7:0] clock_mode_nxt;
   reg [7:0] int_enable_nxt;
   reg [7:0] operand_nxt;
   reg [7:0] high_result_nxt;
   reg [7:0] work_low_nxt;
   localparam [7:0] REQ_RESET = `RST_INT_REQUEST;
   wire [15:0] product;
   wire [7:0] src_evt;
   wire [2:0] sel;
   wire wr_flags;
   wire wr_req;
   assign wr_flags = i_io_wr && (i_io_addr == `ADDR_ALU_STATUS_FLAGS);
   assign wr_req = i_io_wr && (i_io_addr == `ADDR_INTERRUPT_REQUEST);
   assign product = i_work_register * operand_r;
   // Build-time source choice for the shared request bits
   assign src_evt[7] = BIT7_USES_GENERATOR_TWO ? i_pulse_generator_two_evt :
                       i_third_timer_evt;
   assign src_evt[6] = i_second_timer_evt;
   assign src_evt[5] = i_pulse_generator_zero_evt;
   assign src_evt[4] = BIT4_USES_GENERATOR_ONE ? i_pulse_generator_one_evt :
                       i_comparator_evt;
   assign src_evt[3] = i_adc_evt;
   assign src_evt[2] = i_sixteen_bit_timer_evt;
   assign src_evt[1] = i_pin_pair_b_evt;
   assign src_evt[0] = i_pin_pair_a_evt;

   // Next values of the software-visible registers
   always @*
   begin
      stack_pointer_nxt = stack_pointer_r;
      clock_mode_nxt = clock_mode_r;
      int_enable_nxt = int_enable_r;
      operand_nxt = operand_r;
      high_result_nxt = high_result_r;
      work_low_nxt = o_work_register_low;
      if (i_mul_go)
      begin
         high_result_nxt = product[15:8];
         work_low_nxt = product[7:0];
      end
      if (i_io_wr)
      begin
         case (i_io_addr)
            `ADDR_STACK_POINTER:
            begin
               stack_pointer_nxt = i_io_wdata;
            end
            `ADDR_CLOCK_MODE_CONTROL:
            begin
               clock_mode_nxt = i_io_wdata;
            end
            `ADDR_INTERRUPT_ENABLE_MASK:
            begin
               int_enable_nxt = i_io_wdata;
            end
            `ADDR_MULTIPLIER_OPERAND:
            begin
               operand_nxt = i_io_wdata;
            end
            default:
            begin
               // High result and unmapped writes are dropped
            end
         endcase
      end
   end

   // Load pulse follows the product request by one cycle
   always @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         stack_pointer_r <= `RST_STACK_POINTER;
         clock_mode_r <= `RST_CLOCK_MODE;
         int_enable_r <= `RST_INT_ENABLE;
         operand_r <= `RST_OPERAND;
         high_result_r <= `RST_HIGH_RESULT;
         o_work_register_low <= 8'h00;
         o_work_register_load <= 1'b0;
      end
      else
      begin
         stack_pointer_r <= stack_pointer_nxt;
         clock_mode_r <= clock_mode_nxt;
         int_enable_r <= int_enable_nxt;
         operand_r <= operand_nxt;
         high_result_r <= high_result_nxt;
         o_work_register_low <= work_low_nxt;
         o_work_register_load <= i_mul_go;
      end
   end

   // Core updates win over a same-cycle software write
   always @*
   begin
      flags_nxt = flags_r;
      if (wr_flags)
      begin
         flags_nxt = i_io_wdata[3:0];
      end
      if (i_flag_zero_we)
      begin
         flags_nxt[`FLAG_ZERO_POS] = i_flag_zero;
      end
      if (i_flag_carry_we)
      begin
         flags_nxt[`FLAG_CARRY_POS] = i_flag_carry;
      end
      if (i_flag_half_carry_we)
      begin
         flags_nxt[`FLAG_HALF_CARRY_POS] = i_flag_half_carry;
      end
      if (i_flag_signed_wrap_we)
      begin
         flags_nxt[`FLAG_SIGNED_WRAP_POS] = i_flag_signed_wrap;
      end
   end

   always @(posedge i_mclk)
   begin
      if (i_reset)
         flags_r <= `RST_FLAGS;
      else
         flags_r <= flags_nxt;
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : req_bits
         always @(posedge i_mclk)
         begin
            // Set wins over a same-cycle software clear
            if (i_reset)
            begin
               int_request_r[g] <= REQ_RESET[g];
            end
            else if (src_evt[g])
            begin
               int_request_r[g] <= 1'b1;
            end
            else if (wr_req && !i_io_wdata[g])
            begin
               int_request_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign o_irq_pending = int_request_r & int_enable_r;
   assign o_irq = |o_irq_pending;

   always @*
   begin
      case (i_io_addr)
         `ADDR_ALU_STATUS_FLAGS: o_io_rdata = {4'h0, flags_r};
         `ADDR_STACK_POINTER: o_io_rdata = stack_pointer_r;
         `ADDR_CLOCK_MODE_CONTROL: o_io_rdata = clock_mode_r;
         `ADDR_INTERRUPT_ENABLE_MASK: o_io_rdata = int_enable_r;
         `ADDR_INTERRUPT_REQUEST: o_io_rdata = int_request_r;
         `ADDR_MULTIPLIER_OPERAND: o_io_rdata = operand_r;
         `ADDR_MULTIPLIER_HIGH_RESULT: o_io_rdata = high_result_r;
         default: o_io_rdata = 8'h00;
      endcase
   end

   assign o_stack_pointer = stack_pointer_r;
   assign o_alu_status_flags = flags_r;
   assign sel = clock_mode_r[`CLK_SEL_LSB+2:`CLK_SEL_LSB];
   assign o_fast_internal_oscillator_en =
      clock_mode_r[`CLK_FAST_OSC_POS];
   assign o_slow_internal_oscillator_en =
      clock_mode_r[`CLK_SLOW_OSC_POS];
   assign o_watchdog_run = clock_mode_r[`CLK_WATCHDOG_POS] &&
      clock_mode_r[`CLK_SLOW_OSC_POS];
   assign o_external_reset_pin_en = clock_mode_r[`CLK_PIN_FUNC_POS];

   // Divide ratio is given as a power of two
   always @*
   begin
      o_clk_sel_reserved = 1'b0;
      o_clk_source = `SRC_NONE;
      o_clk_divide_log2 = 7'h0;
      if (!clock_mode_r[`CLK_TYPE_POS])
      begin
         case (sel)
            3'h0:
            begin
               o_clk_source = `SRC_FAST;
               o_clk_divide_log2 = 7'h2;
            end
            3'h1:
            begin
               o_clk_source = `SRC_FAST;
               o_clk_divide_log2 = 7'h1;
            end
            3'h3:
            begin
               o_clk_source = `SRC_CRYSTAL;
               o_clk_divide_log2 = 7'h2;
            end
            3'h4:
            begin
               o_clk_source = `SRC_CRYSTAL;
               o_clk_divide_log2 = 7'h1;
            end
            3'h5:
            begin
               o_clk_source = `SRC_CRYSTAL;
            end
            3'h6:
            begin
               o_clk_source = `SRC_SLOW;
               o_clk_divide_log2 = 7'h2;
            end
            3'h7:
            begin
               o_clk_source = `SRC_SLOW;
            end
            default:
            begin
               o_clk_sel_reserved = 1'b1;
            end
         endcase
      end
      else
      begin
         case (sel)
            3'h0:
            begin
               o_clk_source = `SRC_FAST;
               o_clk_divide_log2 = 7'h4;
            end
            3'h1:
            begin
               o_clk_source = `SRC_FAST;
               o_clk_divide_log2 = 7'h3;
            end
            3'h2:
            begin
               o_clk_source = `SRC_SLOW;
               o_clk_divide_log2 = 7'h4;
            end
            3'h3:
            begin
               o_clk_source = `SRC_FAST;
               o_clk_divide_log2 = 7'h5;
            end
            3'h4:
            begin
               o_clk_source = `SRC_FAST;
               o_clk_divide_log2 = 7'h6;
            end
            3'h5:
            begin
               o_clk_source = `SRC_CRYSTAL;
               o_clk_divide_log2 = 7'h3;
            end
            default:
            begin
               o_clk_sel_reserved = 1'b1;
            end
         endcase
      end
   end
endmodule

/* File: core_model.sv */
`timescale 1ns/10ps
module core_model (
   input wire logic i_mclk,
   input wire logic [7:0] i_rdata,
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic [7:0] o_wdata,
   output logic o_go,
   output logic [7:0] o_work
);
   initial {o_addr, o_wr, o_wdata, o_go, o_work} = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk) #1;
      {o_addr, o_wr, o_wdata} = {a, 1'b1, d};
      @(posedge i_mclk) #1;
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk) #1;
      o_addr = a;
      @(posedge i_mclk);
      d = i_rdata;
      #1;
   endtask
   // Operand register loaded before the product request
   task automatic mul(input logic [7:0] a, input logic [7:0] b);
      wr(8'h08, a);
      o_work = b;
      o_go = 1'b1;
      @(posedge i_mclk) #1;
      o_go = 1'b0;
      o_work = ~b;
   endtask
endmodule

/* File: core_regs_checker.sv */
`timescale 1ns/10ps
module core_regs_checker (
   input wire i_mclk,
   input wire i_reset,
   input wire [7:0] i_io_addr,
   input wire i_io_wr,
   input wire [7:0] i_io_wdata,
   input wire i_mul_go,
   input wire [7:0] i_work_register,
   input wire [7:0] o_work_register_low,
   input wire o_work_register_load,
   input wire i_flag_zero_we,
   input wire i_flag_zero,
   input wire i_flag_carry_we,
   input wire i_flag_carry,
   input wire o_irq,
   input wire [7:0] o_irq_pending,
   input wire [7:0] o_stack_pointer,
   input wire [3:0] o_alu_status_flags,
   input wire o_fast_internal_oscillator_en,
   input wire o_slow_internal_oscillator_en,
   input wire o_watchdog_run,
   input wire o_external_reset_pin_en
);
   logic [7:0] op_r;
   logic [15:0] prod_r;
   logic [7:0] en_r;
   always @(posedge i_mclk)
   begin
      prod_r <= op_r * i_work_register;
      if (i_reset)
         en_r <= 8'h00;
      else if (i_io_wr && i_io_addr == 8'h04)
         en_r <= i_io_wdata;
      if (i_reset)
         op_r <= 8'h00;
      else if (i_io_wr && i_io_addr == 8'h08)
         op_r <= i_io_wdata;
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   mul_load_a: assert property (i_mul_go |=> o_work_register_load)
      else $error("no load pulse");
   mul_low_a: assert property (
      i_mul_go |=> o_work_register_low == prod_r[7:0])
      else $error("bad low product");
   sp_write_a: assert property (
      i_io_wr && i_io_addr == 8'h02 |=> o_stack_pointer == $past(i_io_wdata))
      else $error("stack pointer not written");
   zero_flag_a: assert property (
      i_flag_zero_we |=> o_alu_status_flags[0] == $past(i_flag_zero))
      else $error("zero flag wrong");
   carry_flag_a: assert property (
      i_flag_carry_we |=> o_alu_status_flags[1] == $past(i_flag_carry))
      else $error("carry flag wrong");
   irq_gate_a: assert property (o_irq == (o_irq_pending != 8'h00))
      else $error("irq not matching pending");
   pend_mask_a: assert property (
      (o_irq_pending & ~en_r) == 8'h00)
      else $error("pending bit without enable");
   wdog_gate_a: assert property (
      !o_slow_internal_oscillator_en |-> !o_watchdog_run)
      else $error("watchdog runs without slow osc");
   clk_reset_a: assert property ($fell(i_reset) |->
      o_fast_internal_oscillator_en && o_watchdog_run &&
      !o_external_reset_pin_en)
      else $error("clock mode reset value wrong");
endmodule
bind core_status_clock_irq_regs core_regs_checker u_chk (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_io_addr(i_io_addr),
   .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .i_mul_go(i_mul_go),
   .i_work_register(i_work_register),
   .o_work_register_low(o_work_register_low),
   .o_work_register_load(o_work_register_load),
   .i_flag_zero_we(i_flag_zero_we), .i_flag_zero(i_flag_zero),
   .i_flag_carry_we(i_flag_carry_we), .i_flag_carry(i_flag_carry),
   .o_irq(o_irq), .o_irq_pending(o_irq_pending),
   .o_stack_pointer(o_stack_pointer),
   .o_alu_status_flags(o_alu_status_flags),
   .o_fast_internal_oscillator_en(o_fast_internal_oscillator_en),
   .o_slow_internal_oscillator_en(o_slow_internal_oscillator_en),
   .o_watchdog_run(o_watchdog_run),
   .o_external_reset_pin_en(o_external_reset_pin_en));

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
   logic i_mclk = 1'b0;
   logic i_reset = 1'b1;
   logic [9:0] ev = '0;
   logic [7:0] fl = '0;
   logic [7:0] addr, wdata, work, rdata, low, pend, sp, d;
   logic wr, go, load, irq, res, fast, slow, wdog, pin;
   logic [3:0] flags;
   logic [1:0] src;
   logic [6:0] dlog;
   int num_errors = 0;
   int total_checks = 0;
   // Rows: address, reset, written, read back; flags row
   logic [31:0] rows [8] = '{32'h00000a0a, 32'h02005e5e, 32'h03f62c2c,
      32'h0400a5a5, 32'h0500ff00, 32'h08003c3c, 32'h09007700, 32'h07009900};
   // Per clock code: reserved, source, divide exponent
   logic [7:0] ct [16] = '{8'h02, 8'h01, 8'he0, 8'h42, 8'h41, 8'h40, 8'h22,
      8'h20, 8'h04, 8'h03, 8'h24, 8'h05, 8'h06, 8'h43, 8'he0, 8'he0};
   always #5 i_mclk = ~i_mclk;
   core_model u_core_model (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr),
      .o_wr(wr), .o_wdata(wdata), .o_go(go), .o_work(work));
   core_status_clock_irq_regs u_core_status_clock_irq_regs (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_io_addr(addr), .i_io_wr(wr),
      .i_io_wdata(wdata), .i_io_rd(1'b0), .o_io_rdata(rdata), .i_mul_go(go),
      .i_work_register(work), .o_work_register_low(low),
      .o_work_register_load(load), .i_flag_zero_we(fl[7]),
      .i_flag_zero(fl[6]), .i_flag_carry_we(fl[5]), .i_flag_carry(fl[4]),
      .i_flag_half_carry_we(fl[3]), .i_flag_half_carry(fl[2]),
      .i_flag_signed_wrap_we(fl[1]), .i_flag_signed_wrap(fl[0]),
      .i_third_timer_evt(ev[7]), .i_pulse_generator_two_evt(ev[9]),
      .i_second_timer_evt(ev[6]), .i_pulse_generator_zero_evt(ev[5]),
      .i_comparator_evt(ev[4]), .i_pulse_generator_one_evt(ev[8]),
      .i_adc_evt(ev[3]), .i_sixteen_bit_timer_evt(ev[2]),
      .i_pin_pair_b_evt(ev[1]), .i_pin_pair_a_evt(ev[0]), .o_irq(irq),
      .o_irq_pending(pend), .o_stack_pointer(sp), .o_alu_status_flags(flags),
      .o_clk_source(src), .o_clk_divide_log2(dlog), .o_clk_sel_reserved(res),
      .o_fast_internal_oscillator_en(fast),
      .o_slow_internal_oscillator_en(slow), .o_watchdog_run(wdog),
      .o_external_reset_pin_en(pin));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic mulchk(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = a * b;
      u_core_model.mul(a, b);
      chk("load", {7'h00, load}, 8'h01);
      chk("low", low, p[7:0]);
      u_core_model.rd(8'h09, d);
      chk("high", d, p[15:8]);
   endtask
   initial
   begin
      #200000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      repeat (20) @(posedge i_mclk);
      #1 i_reset = 1'b0;
      // Stack pointer row keeps bit 0 clear
      foreach (rows[i])
      begin
         u_core_model.rd(rows[i][31:24], d);
         chk("reset", d, rows[i][23:16]);
         u_core_model.wr(rows[i][31:24], rows[i][15:8]);
         u_core_model.rd(rows[i][31:24], d);
         chk("rw", d, rows[i][7:0]);
      end
      for (int c = 0; c < 16; c++)
      begin
         u_core_model.wr(8'h03, {c[2:0], 1'b1, c[3], 3'b110});
         chk("clk", {res, src, dlog[4:0] & {5{~res}}}, ct[c]);
      end
      u_core_model.wr(8'h03, 8'he2);
      chk("en", {fast, slow, wdog, pin}, 8'h00);
      u_core_model.wr(8'h03, 8'hf7);
      chk("en", {fast, slow, wdog, pin}, 8'h0f);
      mulchk(8'hff, 8'hff);
      mulchk(8'h10, 8'h23);
      mulchk(8'h00, 8'hc3);
      fl = 8'hee;
      @(posedge i_mclk) #1;
      fl = 8'h00;
      chk("flags", {4'h0, flags}, 8'h05);
      ev = 10'h300;
      @(posedge i_mclk) #1;
      ev = 10'h0ff;
      chk("pend", pend, 8'h00);
      @(posedge i_mclk) #1;
      ev = '0;
      chk("pend", pend, 8'ha5);
      u_core_model.rd(8'h05, d);
      chk("req", d, 8'hff);
      u_core_model.wr(8'h05, 8'h5a);
      chk("irq", {pend[7:1], irq}, 8'h00);
      u_core_model.rd(8'h05, d);
      chk("req", d, 8'h5a);
      // Event and clear in one cycle: the event wins
      fork
         u_core_model.wr(8'h05, 8'h00);
         begin
            @(posedge i_mclk) #1;
            ev[0] = 1'b1;
            @(posedge i_mclk) #1;
            ev[0] = 1'b0;
         end
      join
      u_core_model.rd(8'h05, d);
      chk("req set", d, 8'h01);
      // Reset in mid-run restores the defaults
      i_reset = 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 i_reset = 1'b0;
      u_core_model.rd(8'h03, d);
      chk("rst clk", d, 8'hf6);
      u_core_model.rd(8'h05, d);
      chk("rst req", d, 8'h00);
      chk("rst sp", sp, 8'h00);
      chk("rst flags", {4'h0, flags}, 8'h00);
      chk("rst en", {fast, slow, wdog, pin}, 8'h0e);
      print_verdict();
   end
endmodule
